// >>> aal_pkg.sv
// package of constants for the accumulator alu datapath
// Function
// - an instruction that changes the program counter or whose test is true takes two cycles, the second a no-operation.
// - an access to an indirect window whose pointer has its top bit set takes one extra cycle.
// - pointer_literal_add sign-extends a 6-bit literal and adds it to the selected 16-bit pointer without touching flags.
// - the pointer sum wraps modulo 65536 at both ends.
// - add_immediate adds the literal to the working register and updates carry, digit carry and zero.
// - add_register adds the working register to file register f, destination bit choosing working or file register.
// - add_register_with_carry adds working register, file register and carry, to the chosen destination, updating three flags.
// - and_immediate ands the working register with the literal into the working register, touching only zero.
// - and_register ands the working register with the file register into the chosen destination, touching only zero.
// - arithmetic_shift_right shifts f right keeping bit 7, bit 0 goes to carry, only carry and zero change.
// - opcode 11 1110 kkkkkkkk is add_immediate, done in one cycle.
// - opcode 11 0001 0 n kkkkkk is pointer_literal_add, done in one cycle.
// - opcode 11 1001 kkkkkkkk is and_immediate, touching only zero.
package aal_pkg;
  localparam logic [13:0] aal_add_imm_val   = 14'h3E00;
  localparam logic [13:0] aal_and_imm_val   = 14'h3900;
  localparam logic [13:0] aal_ptr_add_val   = 14'h3100;
  localparam logic [13:0] aal_ptr_add_mask  = 14'h3F80;
  localparam logic [13:0] aal_lit_mask      = 14'h3F00;
  localparam logic [13:0] aal_add_reg_val   = 14'h0700;
  localparam logic [13:0] aal_addc_reg_val  = 14'h3D00;
  localparam logic [13:0] aal_and_reg_val   = 14'h0500;
  localparam logic [13:0] aal_asr_val       = 14'h3700;
  localparam logic [13:0] aal_reg_mask      = 14'h3F00;
  localparam int          aal_dest_bit      = 7;
  localparam int          aal_ptr_idx_bit   = 6;
  localparam int          aal_ptr_msb       = 15;
  localparam logic [7:0]  aal_w_reset       = 8'h00;
  localparam logic [15:0] aal_ptr_reset     = 16'h0000;
  localparam logic [1:0]  aal_extra_none    = 2'h0;
  localparam int          aal_ptr_count     = 2;
  localparam logic        aal_flag_reset    = 1'h0;
  localparam logic [6:0]  aal_addr_reset    = 7'h00;
  localparam logic [7:0]  aal_wdata_reset   = 8'h00;
  typedef enum logic [2:0] {
    aal_op_none, aal_op_add_imm, aal_op_and_imm, aal_op_ptr_add,
    aal_op_add_reg, aal_op_addc_reg, aal_op_and_reg, aal_op_asr
  } aal_op_type;
endpackage

// >>> aal_flags.sv
// flag and result generator for the accumulator alu
module aal_flags import aal_pkg::*; (
  // operands
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       cin,
  input  aal_op_type      op,
  // result
  output logic [7:0]      result,
  output logic            carry,
  output logic            digit_carry,
  output logic            zero,
  output logic            carry_we,
  output logic            digit_carry_we,
  output logic            zero_we
);
  logic [4:0] low_sum;
  logic [8:0] full_sum;
  logic       use_cin;

  always_comb begin
    use_cin  = (op == aal_op_addc_reg);
    low_sum  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, use_cin & cin};
    full_sum = {1'b0, a} + {1'b0, b} + {8'h00, use_cin & cin};
    result         = 8'h00;
    carry          = 1'b0;
    digit_carry    = 1'b0;
    carry_we       = 1'b0;
    digit_carry_we = 1'b0;
    zero_we        = 1'b0;
    unique case (op)
      aal_op_add_imm, aal_op_add_reg, aal_op_addc_reg: begin
        result         = full_sum[7:0];
        carry          = full_sum[8];
        digit_carry    = low_sum[4];
        carry_we       = 1'b1;
        digit_carry_we = 1'b1;
        zero_we        = 1'b1;
      end
      aal_op_and_imm, aal_op_and_reg: begin
        result  = a & b;
        zero_we = 1'b1;
      end
      aal_op_asr: begin
        result   = {b[7], b[7:1]};
        carry    = b[0];
        carry_we = 1'b1;
        zero_we  = 1'b1;
      end
      aal_op_none, aal_op_ptr_add: begin
        result = 8'h00;
      end
    endcase
    zero = (result == 8'h00);
  end
endmodule

// >>> aal_core.sv
// execution datapath for the accumulator instruction subset
module aal_core import aal_pkg::*; (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // instruction issue
  input  wire logic        instr_valid,
  input  wire logic [13:0] instr,
  input  wire logic        pc_modified,
  input  wire logic        cond_true,
  input  wire logic        indirect_access,
  input  wire logic        indirect_sel,
  // file register port
  input  wire logic [7:0]  file_rdata,
  output logic [6:0]       file_addr,
  output logic [7:0]       file_wdata,
  output logic             file_we,
  // state
  output logic [7:0]       w_out,
  output logic             carry_flag,
  output logic             digit_carry_flag,
  output logic             zero_flag,
  output logic [15:0]      indirect_pointer_0,
  output logic [15:0]      indirect_pointer_1,
  output logic             busy
);
  // ********************************************
  // decode
  // ********************************************
  // literal forms are tested first, then pointer add, then the register forms
  function automatic aal_op_type decode(input logic [13:0] ins);
    aal_op_type o;
    o = aal_op_none;
    if ((ins & aal_lit_mask) == aal_add_imm_val) o = aal_op_add_imm;
    else if ((ins & aal_lit_mask) == aal_and_imm_val) o = aal_op_and_imm;
    else if ((ins & aal_ptr_add_mask) == aal_ptr_add_val) o = aal_op_ptr_add;
    else if ((ins & aal_reg_mask) == aal_add_reg_val) o = aal_op_add_reg;
    else if ((ins & aal_reg_mask) == aal_addc_reg_val) o = aal_op_addc_reg;
    else if ((ins & aal_reg_mask) == aal_and_reg_val) o = aal_op_and_reg;
    else if ((ins & aal_reg_mask) == aal_asr_val) o = aal_op_asr;
    return o;
  endfunction

  // register-operand instructions share the destination bit and read the file port
  function automatic logic is_reg_op(input aal_op_type o);
    return (o == aal_op_add_reg) || (o == aal_op_addc_reg) || (o == aal_op_and_reg) || (o == aal_op_asr);
  endfunction

  // literal instructions take operand b from the instruction and always land in w
  function automatic logic is_imm_op(input aal_op_type o);
    return (o == aal_op_add_imm) || (o == aal_op_and_imm);
  endfunction

  // ********************************************
  // state and wiring
  // ********************************************
  logic [7:0]  w_reg;
  logic        c_reg;
  logic        dc_reg;
  logic        z_reg;
  logic [15:0] ptr_reg [aal_ptr_count];
  logic [1:0]  extra_reg;
  logic [1:0]  extra_next;
  logic [7:0]  addr_w_reg;
  logic [6:0]  addr_reg;
  logic        we_reg;
  aal_op_type  op;
  logic        accept;
  logic        to_file;
  logic [7:0]  alu_b;
  logic [7:0]  result;
  logic        c_new;
  logic        dc_new;
  logic        z_new;
  logic        c_we;
  logic        dc_we;
  logic        z_we;
  logic [15:0] ptr_sum;
  logic        ptr_idx;
  logic [15:0] lit_sext;
  logic        sel_ptr_msb;
  logic [1:0]  pc_extra;
  logic [1:0]  ind_extra;

  // ********************************************
  // operation
  // ********************************************
  // instruction fields sit at fixed bit positions, valid or not
  always_comb begin
    to_file  = instr[aal_dest_bit];
    ptr_idx  = instr[aal_ptr_idx_bit];
    lit_sext = {{10{instr[5]}}, instr[5:0]};
  end

  always_comb begin
    accept  = instr_valid && (extra_reg == aal_extra_none);
    op      = accept ? decode(instr) : aal_op_none;
    alu_b   = is_imm_op(op) ? instr[7:0] : file_rdata;
    // the carry out of bit 15 is dropped on purpose, which gives the wraparound at both ends
    ptr_sum = ptr_reg[ptr_idx] + lit_sext;
  end

  // ********************************************
  // alu
  // ********************************************
  aal_flags u_flags (
    .a              (w_reg),
    .b              (alu_b),
    .cin            (c_reg),
    .op             (op),
    .result         (result),
    .carry          (c_new),
    .digit_carry    (dc_new),
    .zero           (z_new),
    .carry_we       (c_we),
    .digit_carry_we (dc_we),
    .zero_we        (z_we)
  );

  // ********************************************
  // extra cycles
  // ********************************************
  // the stalled issue slot is the no-operation cycle: nothing is accepted while busy
  always_comb begin
    sel_ptr_msb = ptr_reg[indirect_sel][aal_ptr_msb];
    pc_extra    = {1'b0, pc_modified | cond_true};
    ind_extra   = {1'b0, indirect_access & sel_ptr_msb};
    extra_next  = (extra_reg == aal_extra_none) ? aal_extra_none : extra_reg - 2'h1;
    if (accept) begin
      // both causes stack, so one instruction can stall for two cycles
      extra_next = pc_extra + ind_extra;
    end
  end

  // the stall count is the only state that gates issue
  always_ff @(posedge clk) begin
    if (reset) extra_reg <= aal_extra_none;
    else extra_reg <= extra_next;
  end

  // ********************************************
  // working register
  // ********************************************
  // pointer-add and undecoded words leave w alone
  always_ff @(posedge clk) begin
    if (reset) w_reg <= aal_w_reset;
    else if (is_imm_op(op)) w_reg <= result;
    else if (is_reg_op(op) && !to_file) w_reg <= result;
  end

  // ********************************************
  // flags, pointer-add leaves them alone
  // ********************************************
  // each flag has its own write enable, so an operation touches only the flags it names
  always_ff @(posedge clk) begin
    if (reset) c_reg <= aal_flag_reset;
    else if (c_we) c_reg <= c_new;
  end

  always_ff @(posedge clk) begin
    if (reset) dc_reg <= aal_flag_reset;
    else if (dc_we) dc_reg <= dc_new;
  end

  always_ff @(posedge clk) begin
    if (reset) z_reg <= aal_flag_reset;
    else if (z_we) z_reg <= z_new;
  end

  // ********************************************
  // indirect pointers
  // ********************************************
  // one 16-bit register per pointer; only the indexed register takes the sum
  genvar gi;
  generate
    for (gi = 0; gi < aal_ptr_count; gi++) begin : g_ptr
      localparam logic this_idx = 1'(gi);
      always_ff @(posedge clk) begin
        if (reset) ptr_reg[gi] <= aal_ptr_reset;
        else if ((op == aal_op_ptr_add) && (ptr_idx == this_idx)) ptr_reg[gi] <= ptr_sum;
      end
    end
  endgenerate

  // ********************************************
  // file register write-back
  // ********************************************
  // write-back is one cycle late so that file_wdata comes straight from a flip-flop
  // the address and data are latched every cycle; they only matter while we_reg is high
  always_ff @(posedge clk) begin
    if (reset) we_reg <= 1'b0;
    else we_reg <= is_reg_op(op) && to_file;
  end

  always_ff @(posedge clk) begin
    if (reset) addr_reg <= aal_addr_reset;
    else addr_reg <= instr[6:0];
  end

  always_ff @(posedge clk) begin
    if (reset) addr_w_reg <= aal_wdata_reset;
    else addr_w_reg <= result;
  end

  // read address is the instruction field combinationally, write uses the latched one
  // limitation: a register instruction issued in the write-back cycle reads the written address
  always_comb begin
    file_addr = we_reg ? addr_reg : instr[6:0];
  end

  // ********************************************
  // outputs
  // ********************************************
  assign file_wdata         = addr_w_reg;
  assign file_we            = we_reg;
  assign w_out              = w_reg;
  assign carry_flag         = c_reg;
  assign digit_carry_flag   = dc_reg;
  assign zero_flag          = z_reg;
  assign indirect_pointer_0 = ptr_reg[0];
  assign indirect_pointer_1 = ptr_reg[1];
  // busy decodes only the stall count flip-flops, never the incoming instruction
  assign busy               = (extra_reg != aal_extra_none);
endmodule

// >>> aal_core_monitor.sv
// checker of the accumulator alu execution rules
module aal_core_monitor (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // issue and state
  input wire logic        instr_valid,
  input wire logic [13:0] instr,
  input wire logic        pc_modified,
  input wire logic        cond_true,
  input wire logic        indirect_access,
  input wire logic        indirect_sel,
  input wire logic [7:0]  file_rdata,
  input wire logic [6:0]  file_addr,
  input wire logic        file_we,
  input wire logic [7:0]  w_out,
  input wire logic        carry_flag,
  input wire logic        digit_carry_flag,
  input wire logic        zero_flag,
  input wire logic [15:0] indirect_pointer_0,
  input wire logic [15:0] indirect_pointer_1,
  input wire logic        busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // helpers
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic        take, pc2, ind2;
  logic [8:0]  sum_imm;
  logic [7:0]  and_val, asr_val;
  logic [15:0] sext;
  logic [2:0]  flg;
  assign take = instr_valid && !busy;
  assign pc2 = pc_modified || cond_true;
  assign ind2 = indirect_access && (indirect_sel ? indirect_pointer_1[15] : indirect_pointer_0[15]);
  assign sum_imm = {1'b0, w_out} + {1'b0, instr[7:0]};
  assign and_val = w_out & instr[7:0];
  assign asr_val = {file_rdata[7], file_rdata[7:1]};
  assign sext = {{10{instr[5]}}, instr[5:0]};
  assign flg = {carry_flag, digit_carry_flag, zero_flag};
  AST_ADD_IMM: assert property (
    take && instr[13:8] == 6'h3E |=> {carry_flag, w_out} == $past(sum_imm) && zero_flag == (w_out == 8'h00))
    else $error("add immediate result wrong");
  AST_AND_IMM: assert property (
    take && instr[13:8] == 6'h39 |=> w_out == $past(and_val) && carry_flag == $past(carry_flag)
    && digit_carry_flag == $past(digit_carry_flag)) else $error("and immediate result wrong");
  AST_PTR0: assert property (
    take && (instr & 14'h3F80) == 14'h3100 && !instr[6]
    |=> indirect_pointer_0 == $past(indirect_pointer_0) + $past(sext) && flg == $past(flg))
    else $error("pointer zero sum wrong");
  AST_PTR1: assert property (
    take && (instr & 14'h3F80) == 14'h3100 && instr[6]
    |=> indirect_pointer_1 == $past(indirect_pointer_1) + $past(sext)) else $error("pointer one sum wrong");
  AST_EXTRA1: assert property (
    take && (pc2 ^ ind2) |=> busy ##1 !busy) else $error("single extra cycle wrong");
  AST_EXTRA2: assert property (
    take && pc2 && ind2 |=> busy [*2] ##1 !busy) else $error("double extra cycle wrong");
  AST_ONE: assert property (
    take && !pc2 && !ind2 |=> !busy) else $error("single cycle op stalled");
  AST_WB: assert property (
    take && instr[7] && (instr[13:8] inside {6'h07, 6'h3D, 6'h05, 6'h37})
    |=> file_we && file_addr == $past(instr[6:0])) else $error("write back missing");
  AST_ASR: assert property (
    take && instr[13:7] == 7'h6E |=> w_out == $past(asr_val) && carry_flag == $past(file_rdata[0]))
    else $error("shift result wrong");
  cover property (take && pc2 && ind2);
  cover property (file_we);
  cover property (take && instr[13:7] == 7'h62);
endmodule

bind aal_core aal_core_monitor mon (.clk(clk), .reset(reset), .instr_valid(instr_valid), .instr(instr),
  .pc_modified(pc_modified), .cond_true(cond_true), .indirect_access(indirect_access),
  .indirect_sel(indirect_sel), .file_rdata(file_rdata), .file_addr(file_addr), .file_we(file_we),
  .w_out(w_out), .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag),
  .indirect_pointer_0(indirect_pointer_0), .indirect_pointer_1(indirect_pointer_1), .busy(busy));

// >>> aal_core_test.sv
// self-checking bench for the accumulator alu datapath
module aal_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, reset, instr_valid, pc_modified, cond_true, indirect_access, indirect_sel;
  logic        file_we, carry_flag, digit_carry_flag, zero_flag, busy;
  logic [13:0] instr;
  logic [7:0]  file_rdata, file_wdata, w_out;
  logic [6:0]  file_addr;
  logic [15:0] indirect_pointer_0, indirect_pointer_1;
  logic [7:0]  mem [128];
  logic [2:0]  c;
  int          error_cnt, num_checks, cyc;
  logic [13:0] ti [15] = '{14'h3E05, 14'h3EFB, 14'h39FF, 14'h3E96, 14'h3969, 14'h3E7F, 14'h3E01, 14'h0710,
                           14'h3D91, 14'h3EFB, 14'h3D11, 14'h0511, 14'h0590, 14'h3711, 14'h3790};
  logic [10:0] te [15] = '{11'h005, 11'h700, 11'h700, 11'h096, 11'h100, 11'h07F, 11'h280, 11'h405,
                           11'h005, 11'h700, 11'h088, 11'h080, 11'h080, 11'h4C3, 11'h0C3};
  logic [13:0] tp [4] = '{14'h313F, 14'h3101, 14'h315F, 14'h3160};
  logic [15:0] pe [4] = '{16'hFFFF, 16'h0000, 16'h001F, 16'hFFFF};
  logic [3:0]  tc [6] = '{4'h8, 4'h4, 4'h3, 4'h2, 4'hB, 4'hF};
  logic [2:0]  tn [6] = '{3'h1, 3'h1, 3'h1, 3'h0, 3'h2, 3'h2};

  aal_core dut (.clk(clk), .reset(reset), .instr_valid(instr_valid), .instr(instr), .pc_modified(pc_modified),
    .cond_true(cond_true), .indirect_access(indirect_access), .indirect_sel(indirect_sel),
    .file_rdata(file_rdata), .file_addr(file_addr), .file_wdata(file_wdata), .file_we(file_we),
    .w_out(w_out), .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag),
    .indirect_pointer_0(indirect_pointer_0), .indirect_pointer_1(indirect_pointer_1), .busy(busy));

  // ****************
  // file register model and clock
  // ****************
  assign file_rdata = mem[file_addr];
  always @(posedge clk) if (file_we) mem[file_addr] <= file_wdata;
  always #4 clk = ~clk;
  // whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt = error_cnt + 1;
      summarize();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // starts at a falling edge and returns at the next, so calls can run back to back
  task automatic issue(input logic [13:0] i, input logic [3:0] ctl);
    instr_valid = 1'b1;
    instr = i;
    {pc_modified, cond_true, indirect_access, indirect_sel} = ctl;
    @(negedge clk);
  endtask
  task automatic idle;
    instr_valid = 1'b0;
    {pc_modified, cond_true, indirect_access, indirect_sel} = 4'h0;
    @(negedge clk);
  endtask

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    cyc = 0;
    error_cnt = 0;
    num_checks = 0;
    instr = 14'h0000;
    foreach (mem[k]) mem[k] = 8'h00;
    mem[16] = 8'h85;
    mem[17] = 8'h81;
    idle();
    repeat (20) @(negedge clk);
    reset = 1'b0;
    chk(indirect_pointer_0 | indirect_pointer_1, 16'h0000);
    chk({4'h0, busy, carry_flag, digit_carry_flag, zero_flag, w_out}, 16'h0000);
    $display("reset test done");
    for (int k = 0; k < 15; k++) begin
      issue(ti[k], 4'h0);
      chk({5'h00, carry_flag, digit_carry_flag, zero_flag, w_out}, {5'h00, te[k]});
      if (ti[k][7]) idle();
    end
    idle();
    chk({8'h00, mem[17]}, 16'h0087);
    chk({8'h00, mem[16]}, 16'h00C0);
    $display("literal and register test done");
    for (int k = 0; k < 4; k++) begin
      issue(tp[k], 4'h0);
      chk(tp[k][6] ? indirect_pointer_1 : indirect_pointer_0, pe[k]);
    end
    chk({5'h00, carry_flag, digit_carry_flag, zero_flag, w_out}, 16'h00C3);
    $display("pointer test done");
    for (int k = 0; k < 6; k++) begin
      issue(14'h0000, tc[k]);
      c = 3'h0;
      // a literal add held up while stalled must be refused
      while (busy === 1'b1 && c < 3'h4) begin
        c++;
        issue(14'h3E01, 4'h0);
      end
      idle();
      chk({13'h0000, c}, {13'h0000, tn[k]});
      chk({8'h00, w_out}, 16'h00C3);
    end
    $display("stall test done");
    summarize();
  end
endmodule
